// >>> inc/xcvr_consts.vh
// constants for the quad bus transceiver slice
`ifndef XCVR_CONSTS_VH
`define XCVR_CONSTS_VH
`define XCVR_WIDTH 4
`define XCVR_SEL_PORT_A 1'b0
`define XCVR_SEL_PORT_B 1'b1
`define XCVR_DRV_RESET 4'h0
`define XCVR_LATCH_RESET 4'h0
`define XCVR_SYNC_STAGES 3
`endif

// >>> verilog/odd_parity.v
// odd parity generator over a data word
`timescale 1ns/1ps
`default_nettype none
module odd_parity #(
  parameter WIDTH = 4
) (
  input wire [WIDTH-1:0] data,
  output wire parity
);
  // high when the data holds an even count of ones, so the total is odd
  assign parity = ~(^data);
endmodule
`default_nettype wire

// >>> verilog/quad_bus_transceiver_parity.v
// quad three-state bus transceiver with driver register, receive latch and parity
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_consts.vh"
// Contract
// - four-bit driver register, mux per bit
// - select low loads port a, high b
// - register loads only on driver clock rise
// - enable high releases all bus lines
// - enabled bus carries inverted register bits
// - every bus line feeds its own receiver
// - receiver inverts bus, end-to-end non-inverting
// - four receiver latches drive receiver outputs
// - latch enable low: outputs follow bus
// - latch enable high: hold captured value
// - driving: parity of selected input data
// - not driving: parity of latch outputs
module quad_bus_transceiver_parity #(
  parameter WIDTH = `XCVR_WIDTH
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [WIDTH-1:0] port_a,
  input wire [WIDTH-1:0] port_b,
  input wire port_sel,
  input wire driver_register_clock,
  input wire bus_drive_enable_n,
  input wire receiver_latch_enable_n,
  input wire [WIDTH-1:0] bus_in,
  output wire [WIDTH-1:0] bus_out,
  output wire [WIDTH-1:0] bus_oe,
  output wire [WIDTH-1:0] rx_data,
  output wire parity
);
  // pin inputs pass three flops; a change counts when stages two and three agree
  reg [2:0] drclk_sync_q;
  reg [2:0] den_sync_q;
  reg [2:0] rle_sync_q;
  reg [2:0] sel_sync_q;
  reg drclk_q;
  reg den_n_q;
  reg rle_n_q;
  reg sel_q;
  reg [WIDTH-1:0] a_s1_q;
  reg [WIDTH-1:0] a_s2_q;
  reg [WIDTH-1:0] a_s3_q;
  reg [WIDTH-1:0] a_q;
  reg [WIDTH-1:0] b_s1_q;
  reg [WIDTH-1:0] b_s2_q;
  reg [WIDTH-1:0] b_s3_q;
  reg [WIDTH-1:0] b_q;
  reg [WIDTH-1:0] bus_s1_q;
  reg [WIDTH-1:0] bus_s2_q;
  reg [WIDTH-1:0] bus_s3_q;
  reg [WIDTH-1:0] bus_q;
  reg [WIDTH-1:0] drv_q;
  reg [WIDTH-1:0] drv_d;
  reg [WIDTH-1:0] latch_q;
  wire [WIDTH-1:0] rx_inv;
  wire [WIDTH-1:0] parity_src;
  wire drclk_rise;

  // a pulse shorter than one clock period never agrees and is dropped
  function settled_bit;
    input late;
    input later;
    begin
      settled_bit = (late == later);
    end
  endfunction

  // control pins reset to their idle level so no false edge follows reset
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      drclk_sync_q <= 3'h0;
      den_sync_q <= 3'h7;
      rle_sync_q <= 3'h0;
      sel_sync_q <= 3'h0;
    end
    else if (ce)
    begin
      drclk_sync_q <= {drclk_sync_q[1:0], driver_register_clock};
      den_sync_q <= {den_sync_q[1:0], bus_drive_enable_n};
      rle_sync_q <= {rle_sync_q[1:0], receiver_latch_enable_n};
      sel_sync_q <= {sel_sync_q[1:0], port_sel};
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      drclk_q <= 1'b0;
      den_n_q <= 1'b1;
      rle_n_q <= 1'b0;
      sel_q <= `XCVR_SEL_PORT_A;
    end
    else if (ce)
    begin
      if (settled_bit(drclk_sync_q[1], drclk_sync_q[2]))
        drclk_q <= drclk_sync_q[2];
      if (settled_bit(den_sync_q[1], den_sync_q[2]))
        den_n_q <= den_sync_q[2];
      if (settled_bit(rle_sync_q[1], rle_sync_q[2]))
        rle_n_q <= rle_sync_q[2];
      if (settled_bit(sel_sync_q[1], sel_sync_q[2]))
        sel_q <= sel_sync_q[2];
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      a_s1_q <= {WIDTH{1'b0}};
      a_s2_q <= {WIDTH{1'b0}};
      a_s3_q <= {WIDTH{1'b0}};
      a_q <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      a_s1_q <= port_a;
      a_s2_q <= a_s1_q;
      a_s3_q <= a_s2_q;
      if (a_s2_q == a_s3_q)
        a_q <= a_s3_q;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      b_s1_q <= {WIDTH{1'b0}};
      b_s2_q <= {WIDTH{1'b0}};
      b_s3_q <= {WIDTH{1'b0}};
      b_q <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      b_s1_q <= port_b;
      b_s2_q <= b_s1_q;
      b_s3_q <= b_s2_q;
      if (b_s2_q == b_s3_q)
        b_q <= b_s3_q;
    end
  end

  // all-ones reset reads back through the inverter as the latch reset of zero
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_s1_q <= {WIDTH{1'b1}};
      bus_s2_q <= {WIDTH{1'b1}};
      bus_s3_q <= {WIDTH{1'b1}};
      bus_q <= {WIDTH{1'b1}};
    end
    else if (ce)
    begin
      // every bus line reaches the receive path, whoever drives it
      bus_s1_q <= bus_in;
      bus_s2_q <= bus_s1_q;
      bus_s3_q <= bus_s2_q;
      if (bus_s2_q == bus_s3_q)
        bus_q <= bus_s3_q;
    end
  end

  // data and select are filtered like the clock; the outside logic sets them before the edge
  assign drclk_rise = settled_bit(drclk_sync_q[1], drclk_sync_q[2]) & drclk_sync_q[2] & ~drclk_q;

  // per-bit two-input mux in front of each flop
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_mux
      always @*
      begin
        drv_d[i] = (sel_q == `XCVR_SEL_PORT_B) ? b_q[i] : a_q[i];
      end
    end
  endgenerate

  always @(posedge clk or posedge rst)
  begin
    if (rst)
      drv_q <= `XCVR_DRV_RESET;
    else if (ce && drclk_rise)
      drv_q <= drv_d;
  end

  // drive the inverted register only while enabled
  assign bus_out = ~drv_q;
  assign bus_oe = {WIDTH{~den_n_q}};

  assign rx_inv = ~bus_q;

  // latch modelled as a flop that follows while open; one cycle behind the sampled bus
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      latch_q <= `XCVR_LATCH_RESET;
    else if (ce && !rle_n_q)
      latch_q <= rx_inv;
  end

  assign rx_data = latch_q;

  // generate from selected input while driving, else check latched data
  assign parity_src = den_n_q ? latch_q : drv_d;

  odd_parity #(
    .WIDTH(WIDTH)
  ) u_parity (
    .data(parity_src),
    .parity(parity)
  );
endmodule
`default_nettype wire

// >>> verification/xcvr_checker.sv
// port assertions for the transceiver slice
`timescale 1ns/1ps
`default_nettype none
module xcvr_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] port_a,
  input wire logic [3:0] port_b,
  input wire logic port_sel,
  input wire logic driver_register_clock,
  input wire logic bus_drive_enable_n,
  input wire logic receiver_latch_enable_n,
  input wire logic [3:0] bus_in,
  input wire logic [3:0] bus_out,
  input wire logic [3:0] bus_oe,
  input wire logic [3:0] rx_data,
  input wire logic parity
);
  wire logic [8:0] ins = {port_sel, port_a, port_b};
  default clocking @(posedge clk); endclocking
  // ce low freezes the pin filters, so it pauses every check
  default disable iff (rst || !ce);
  a_oe_whole: assert property (bus_oe == 4'h0 || bus_oe == 4'hf) else $error("oe split");
  a_oe_off: assert property (bus_drive_enable_n [*7] |-> !bus_oe) else $error("oe on");
  a_oe_on: assert property (!bus_drive_enable_n [*7] |-> &bus_oe) else $error("oe off");
  a_reg_keep: assert property (!driver_register_clock [*8] |=> $stable(bus_out))
    else $error("reg moved");
  a_rx_follow: assert property ((!receiver_latch_enable_n && $stable(bus_in)) [*8]
    |-> rx_data == ~bus_in) else $error("rx not following");
  a_rx_hold: assert property (receiver_latch_enable_n [*7] |=> $stable(rx_data))
    else $error("rx moved");
  a_par_gen: assert property ((!bus_drive_enable_n && $stable(ins)) [*8]
    |-> parity == ~^(port_sel ? port_b : port_a)) else $error("bad parity");
  a_par_chk: assert property (bus_drive_enable_n [*7] |-> parity == ~^rx_data)
    else $error("bad check parity");
  c_drive: cover property (&bus_oe && parity);
  c_hold: cover property (receiver_latch_enable_n && !bus_oe);
  c_load: cover property ($rose(driver_register_clock));
endmodule
bind quad_bus_transceiver_parity xcvr_checker i_chk (.*);
`default_nettype wire

// >>> verification/bus_far_side.sv
// far side of the bus: a driver that takes over each released line
`timescale 1ns/1ps
`default_nettype none
module bus_far_side (
  input wire logic [3:0] bus_out,
  input wire logic [3:0] bus_oe,
  input wire logic [3:0] val,
  output wire logic [3:0] bus_in
);
  assign bus_in = (bus_oe & bus_out) | (~bus_oe & val);
endmodule
`default_nettype wire

// >>> verification/quad_bus_transceiver_parity_tb.sv
// random bench for the transceiver slice
`timescale 1ns/1ps
`default_nettype none
module quad_bus_transceiver_parity_tb;
  logic clk = 0, rst = 1, sel = 0, dclk = 0, en_n = 1, le_n = 0, par;
  logic [3:0] a = 0, b = 0, v = 0, bus, bo, oe, rx, e;
  integer seed = 32'h52f2, errors = 0, comparisons = 0, cycles = 0, i;
  always #20 clk = ~clk;
  always @(posedge clk)
    if (++cycles == 2000)
      report_and_stop(1);
  quad_bus_transceiver_parity i_dut (.clk(clk), .rst(rst), .ce(1'b1), .port_a(a), .port_b(b),
    .port_sel(sel), .driver_register_clock(dclk), .bus_drive_enable_n(en_n), .bus_in(bus),
    .receiver_latch_enable_n(le_n), .bus_out(bo), .bus_oe(oe), .rx_data(rx), .parity(par));
  bus_far_side i_far (.bus_out(bo), .bus_oe(oe), .val(v), .bus_in(bus));
  task check(input logic [4:0] seen, want);
    comparisons++;
    errors += seen !== want;
    if (seen !== want)
      $display("unexpected at %0t: %h expected %h", $time, seen, want);
  endtask
  function logic [4:0] want_of(input logic [3:0] x);
    return {~^x, x};
  endfunction
  task report_and_stop(input integer late);
    errors += late;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #80 rst = 0;
    for (i = 0; i < 20; i++)
    begin
      // first rounds put an all-zero word on port a and an all-one word on port b, in both modes
      {le_n, en_n, sel, a, b, v} = {1'b0, i[0], i < 4 ? {i[1], 12'h0f5} : 13'($random(seed))};
      #240 dclk = 1;
      #560 e = en_n ? ~v : (sel ? b : a);
      check({par, rx}, want_of(e));
      check({oe[0], bo}, {~en_n, ~(sel ? b : a)});
      {le_n, dclk} = 2'b10;
      // the bus moves only after the closed latch has settled
      #280 {en_n, v} = {1'b1, ~v};
      #320 check({par, rx}, want_of(e));
      check({oe[0], bo}, {1'b0, ~(sel ? b : a)});
    end
    report_and_stop(0);
  end
endmodule
`default_nettype wire
